// ===== pkg/icj_map.vh
// Constants for the inc/dec, interrupt-enable and computed-jump execution block.
// Assumes inclusion by bare name from the design files.
`ifndef ICJ_MAP_VH
`define ICJ_MAP_VH
// Operation select codes
`define ICJ_OP_NONE        3'h0
`define ICJ_OP_MINUS_ONE   3'h1
`define ICJ_OP_PLUS_ONE    3'h2
`define ICJ_OP_PLUS_SKIP   3'h3
`define ICJ_OP_MASK_ALL    3'h4
`define ICJ_OP_UNMASK_ALL  3'h5
`define ICJ_OP_JUMP        3'h6
// Destination bit values
`define ICJ_DEST_WORK      1'h0
`define ICJ_DEST_REG       1'h1
// Reset values
`define ICJ_RST_ALLOW      1'h0
`define ICJ_RST_WORK       8'h00
`define ICJ_RST_PC         11'h000
// Cycle counts
`define ICJ_CYC_ONE        2'h1
`define ICJ_CYC_TWO        2'h2
// Field positions of the program counter
`define ICJ_PC_HI_MSB      10
`define ICJ_PC_HI_LSB      8
`endif

// ===== src/icj_alu.v
// Holds the 8-bit plus/minus one unit with zero detection.
// Assumes a purely combinational use by the execution block on the same clock.
`timescale 1ns/10ps
`default_nettype none
module icj_alu
(
  // Operand and direction
  input  wire [7:0] operand_i,
  input  wire       minus_i,
  // Result
  output wire [7:0] result_o,
  output wire       zero_o
);
  // Eight-bit sum wraps naturally modulo 256
  assign result_o = minus_i ? (operand_i - 8'h01) : (operand_i + 8'h01);
  assign zero_o   = (result_o == 8'h00);
endmodule // icj_alu
`default_nettype wire

// ===== src/icj_exec.v
// Execution block for decrement, increment, increment-skip, interrupt
// mask/unmask and computed jump.
// Assumes the core presents one decoded operation per issue strobe and
// honours busy_o before issuing the next one; all inputs are core-clock logic.
//
// Summary of operation
// - Decrement data register, result to working or data register, updates zero, one cycle.
// - Increment data register, result by destination bit, updates zero, one cycle.
// - Increment-and-skip stores result by destination bit, flags untouched.
// - Zero increment-skip result squashes fetched next instruction, two cycles.
// - Interrupt mask clears global interrupt allow bit in one cycle.
// - Interrupt unmask sets global interrupt allow bit in one cycle.
// - Computed jump loads page pointer low bits and working register; two cycles.
`timescale 1ns/10ps
`default_nettype none
`include "icj_map.vh"
module icj_exec
(
  // Clock and reset
  input  wire        clock_i,
  input  wire        rst_i,
  // Issue
  input  wire        issue_i,
  input  wire [2:0]  op_i,
  input  wire        dest_i,
  input  wire [6:0]  reg_addr_i,
  input  wire [7:0]  reg_data_i,
  input  wire [7:0]  jump_page_pointer_i,
  // Working register and data register write
  output reg  [7:0]  working_register_o,
  output reg         reg_we_o,
  output reg  [6:0]  reg_waddr_o,
  output reg  [7:0]  reg_wdata_o,
  // Status
  output reg         zero_we_o,
  output reg         zero_o,
  output reg         global_interrupt_allow_o,
  // Flow control
  output reg         pc_load_o,
  output reg  [10:0] pc_value_o,
  output reg         squash_o,
  output wire        busy_o,
  output reg         done_o
);
  // ==========================================================
  // State
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg        state_q;
  reg        state_d;
  wire [7:0] alu_res;
  wire       alu_zero;

  // Decode used by several processes
  function is_arith;
    input [2:0] op;
    begin
      is_arith = (op == `ICJ_OP_MINUS_ONE) || (op == `ICJ_OP_PLUS_ONE) ||
                 (op == `ICJ_OP_PLUS_SKIP);
    end
  endfunction

  icj_alu u_alu
  (
    .operand_i (reg_data_i),
    .minus_i   (op_i == `ICJ_OP_MINUS_ONE),
    .result_o  (alu_res),
    .zero_o    (alu_zero)
  );

  // ==========================================================
  // Timing of one instruction
  //   Edge 0: issue_i high and busy_o low, the operation is taken.
  //   Edge 1: results and pulses show up from flip-flops.
  //           One-cycle operations raise done_o here.
  //           A zero skip or a jump raises busy_o here instead.
  //   Edge 2: a two-cycle operation raises done_o and drops busy_o.
  // An issue that arrives while busy_o is high is dropped without trace,
  // so the core must hold its next instruction for that one cycle.
  // The operand comes from the data register in the same cycle as the
  // issue; no bypass is kept here, the core forwards any pending write.

  // ==========================================================
  // Second cycle of a skip or a jump; new issues are held off meanwhile
  assign busy_o = (state_q == ST_WAIT);

  wire take = issue_i && !busy_o;
  wire two_cycle = (op_i == `ICJ_OP_JUMP) ||
                   ((op_i == `ICJ_OP_PLUS_SKIP) && alu_zero);

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (take && two_cycle)
          state_d = ST_WAIT;
      end
      ST_WAIT: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // ==========================================================
  // Result registers
  // Each output group has its own process, so that a change to one
  // instruction cannot disturb the pulses of another.
  wire take_arith = take && is_arith(op_i);
  wire take_skip  = take_arith && (op_i == `ICJ_OP_PLUS_SKIP);

  // Sequencer state
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Done marks the last cycle of each instruction
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      done_o <= 1'b0;
    else
      done_o <= (take && !two_cycle) || busy_o;
  end

  // Working register takes the result when the destination bit is clear
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      working_register_o <= `ICJ_RST_WORK;
    else if (take_arith && (dest_i == `ICJ_DEST_WORK))
      working_register_o <= alu_res;
  end

  // Data register write-back; address and data hold after the pulse
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_we_o    <= 1'b0;
      reg_waddr_o <= 7'h00;
      reg_wdata_o <= 8'h00;
    end
    else
    begin
      reg_we_o <= 1'b0;
      if (take_arith && (dest_i == `ICJ_DEST_REG))
      begin
        reg_we_o    <= 1'b1;
        reg_waddr_o <= reg_addr_i;
        reg_wdata_o <= alu_res;
      end
    end
  end

  // Zero flag; the skip variant leaves it alone so loop tests keep flags
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      zero_we_o <= 1'b0;
      zero_o    <= 1'b0;
    end
    else
    begin
      zero_we_o <= 1'b0;
      if (take_arith && !take_skip)
      begin
        zero_we_o <= 1'b1;
        zero_o    <= alu_zero;
      end
    end
  end

  // Global interrupt allow; a masked core stays masked until unmasked
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      global_interrupt_allow_o <= `ICJ_RST_ALLOW;
    else if (take && (op_i == `ICJ_OP_MASK_ALL))
      global_interrupt_allow_o <= 1'b0;
    else if (take && (op_i == `ICJ_OP_UNMASK_ALL))
      global_interrupt_allow_o <= 1'b1;
  end

  // Computed jump uses the working register from before this cycle
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pc_load_o  <= 1'b0;
      pc_value_o <= `ICJ_RST_PC;
    end
    else
    begin
      pc_load_o <= 1'b0;
      if (take && (op_i == `ICJ_OP_JUMP))
      begin
        pc_load_o  <= 1'b1;
        pc_value_o <= {jump_page_pointer_i[2:0], working_register_o};
      end
    end
  end

  // Squash pulse; the core itself puts a no-operation in the slot
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      squash_o <= 1'b0;
    else
      squash_o <= take_skip && alu_zero;
  end
endmodule // icj_exec
`default_nettype wire

// ===== sim/icj_chk_checker.sv
// Port checker for the inc/dec, interrupt and jump block.
// Assumes a bind onto icj_exec.
`timescale 1ns/10ps
`default_nettype none
module icj_chk
(
  // Control and status
  input wire logic clock_i, rst_i, issue_i, busy_o, dest_i, reg_we_o,
  input wire logic zero_we_o, zero_o, global_interrupt_allow_o,
  input wire logic pc_load_o, squash_o, done_o,
  // Data
  input wire logic [2:0] op_i,
  input wire logic [7:0] reg_data_i, jump_page_pointer_i,
  input wire logic [7:0] working_register_o, reg_wdata_o,
  input wire logic [10:0] pc_value_o
);
  // =====
  // Taken issue, one clock domain
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire tk = issue_i & ~busy_o;
  a_minus_write: assert property (tk && op_i == 3'h1 && dest_i |=> reg_we_o && zero_we_o
    && reg_wdata_o == $past(reg_data_i) - 8'h01) else $error("minus one write wrong");
  a_plus_work: assert property (tk && op_i == 3'h2 && !dest_i |=> zero_we_o
    && working_register_o == $past(reg_data_i) + 8'h01) else $error("plus one wrong");
  a_skip_flags: assert property (tk && op_i == 3'h3 |=> !zero_we_o)
    else $error("skip touched flag");
  a_skip_squash: assert property (tk && op_i == 3'h3 && reg_data_i == 8'hff
    |=> squash_o && busy_o ##1 done_o) else $error("skip not taken");
  a_mask_all: assert property (tk && op_i == 3'h4 |=> !global_interrupt_allow_o)
    else $error("mask failed");
  a_unmask_all: assert property (tk && op_i == 3'h5 |=> global_interrupt_allow_o)
    else $error("unmask failed");
  a_jump_target: assert property (tk && op_i == 3'h6 |=> pc_load_o && pc_value_o ==
    {$past(jump_page_pointer_i[2:0]), $past(working_register_o)} ##1 done_o)
    else $error("jump target wrong");
  a_wrap_zero: assert property (tk && op_i == 3'h2 && reg_data_i == 8'hff |=> zero_o)
    else $error("wrap zero missed");
endmodule // icj_chk
bind icj_exec icj_chk icj_chk_inst (.*);
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for icj_exec.
// Assumes icj_map.vh on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "icj_map.vh"
module tb_top;
  // =====
  // Stimulus, model state and outputs
  logic clock_i = 0, rst_i = 1, issue_i = 0, dest_i = 0;
  logic [2:0] op_i = 0;
  logic [6:0] reg_addr_i = 0;
  logic [7:0] reg_data_i = 0, jump_page_pointer_i = 0;
  logic [15:0] s = 16'h626a;
  integer fails = 0, cmp_count = 0, w = 0, r, i;
  wire [7:0] working_register_o, reg_wdata_o;
  wire [6:0] reg_waddr_o;
  wire [10:0] pc_value_o;
  wire reg_we_o, zero_we_o, zero_o, global_interrupt_allow_o;
  wire pc_load_o, squash_o, busy_o, done_o;
  icj_exec icj_exec_inst (.*);
  always #2 clock_i = ~clock_i;
  // Random source
  function [15:0] nxt(input [15:0] v);
    nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task ck(input c);
    cmp_count = cmp_count + 1;
    if (c !== 1'b1)
    begin
      fails = fails + 1;
      $display("unexpected %0t output mismatch", $time);
    end
  endtask
  // One instruction against the model; waits out the skip or jump cycle
  task ex(input [2:0] o, input d, input [7:0] v);
    s = nxt(s);
    r = (o == `ICJ_OP_MINUS_ONE) ? (v - 1) & 255 : (v + 1) & 255;
    @(posedge clock_i);
    issue_i <= 1; op_i <= o; dest_i <= d; reg_data_i <= v;
    reg_addr_i <= s[6:0]; jump_page_pointer_i <= s[15:8];
    @(posedge clock_i);
    issue_i <= 0;
    #1;
    if (o < 4)
    begin
      if (d) ck(reg_we_o === 1 && reg_wdata_o === r[7:0] && reg_waddr_o === s[6:0]);
      else begin ck(working_register_o === r[7:0]); w = r; end
      ck(zero_we_o === (o != 3) && (o == 3 || zero_o === (r == 0)));
      ck(squash_o === (o == 3 && r == 0));
    end
    if (o == 4 || o == 5) ck(global_interrupt_allow_o === (o == 5));
    if (o == 6) ck(pc_load_o === 1 && pc_value_o === {s[10:8], w[7:0]});
    if (o == 6 || (o == 3 && r == 0))
    begin
      ck(busy_o === 1 && done_o === 0);
      @(posedge clock_i);
      #1;
    end
    ck(done_o === 1);
  endtask
  task conclude;
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Directed edge cases, then random traffic
  initial
  begin
    repeat (4) @(posedge clock_i);
    rst_i <= 0;
    #1 ck(global_interrupt_allow_o === 0 && done_o === 0);
    ex(3'h5, 0, 0); ex(3'h4, 0, 0); ex(3'h5, 0, 0);
    ex(3'h2, 1, 8'hff); ex(3'h1, 1, 8'h01); ex(3'h1, 0, 8'h00);
    ex(3'h2, 0, 8'h7f); ex(3'h3, 1, 8'hff); ex(3'h6, 0, 0);
    $display("directed test done");
    for (i = 0; i < 60; i = i + 1)
    begin
      s = nxt(s);
      ex(s % 6 + 1, s[3], s[15:8]);
    end
    $display("random test done");
    conclude;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #8000;
    fails = fails + 1;
    conclude;
  end
endmodule // tb_top
`default_nettype wire
